// ---- quad_repeater_defs.vh ----
// Constants shared by the repeater configuration logic.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef QUAD_REPEATER_DEFS_VH
`define QUAD_REPEATER_DEFS_VH

// ----------------------------------------------------------------
// Bus address and timing
// ----------------------------------------------------------------
`define TGT_ADDR         7'h56
`define CLK_PERIOD_NS    10
`define T_BUF_NS         4700
`define T_HIGH_MAX_NS    50000
`define T_BUF_CYC        ((`T_BUF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_HIGH_MAX_CYC   (`T_HIGH_MAX_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_STATUS       8'h00
`define REG_CTRL         8'h01
`define REG_BOOST0       8'h02
`define REG_BOOST3       8'h05
`define REG_BOOST_MSB    8'h06
`define REG_DET_ON       8'h07
`define REG_DET_OFF      8'h08
`define REG_LANE_STAT    8'h09

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CTRL_SWING_BUS   0
`define CTRL_EMPH_BUS    1
`define CTRL_SWING_LSB   2
`define CTRL_EMPH_LSB    4
`define CTRL_RST         8'h28
`define BOOST_LO_RST     8'h2F
`define DET_ON_RST       8'h40
`define DET_OFF_RST      8'h20
`define SWING_DEFAULT    2'h2
`define EMPH_DEFAULT     2'h2

// ----------------------------------------------------------------
// Boost patterns for each strap code
// ----------------------------------------------------------------
`define BOOST_P0         9'h000
`define BOOST_P1         9'h001
`define BOOST_P2         9'h003
`define BOOST_P3         9'h007
`define BOOST_P4         9'h00F
`define BOOST_P5         9'h01F
`define BOOST_P6         9'h02F
`define BOOST_P7         9'h03F

`endif

// ---- lane_ctrl.v ----
// One lane's boost selection, signal-present hysteresis and standby.
// Assumes all inputs are already in the CLK_SYS domain.
`timescale 1ns/1ps
`default_nettype none
`include "quad_repeater_defs.vh"

module lane_ctrl #(
  parameter LVL_W = 8
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             ce,
  input  wire             pin_mode,
  input  wire [2:0]       strap_code,
  input  wire [8:0]       bus_boost,
  input  wire [LVL_W-1:0] level,
  input  wire [LVL_W-1:0] on_lvl,
  input  wire [LVL_W-1:0] off_lvl,
  input  wire             power_on,
  output reg  [8:0]       boost_reg,
  output reg              present_reg,
  output reg              active_reg
);

  reg [8:0] strap_boost;

  always @* begin
    case (strap_code)
      3'h0:    strap_boost = `BOOST_P0;
      3'h1:    strap_boost = `BOOST_P1;
      3'h2:    strap_boost = `BOOST_P2;
      3'h3:    strap_boost = `BOOST_P3;
      3'h4:    strap_boost = `BOOST_P4;
      3'h5:    strap_boost = `BOOST_P5;
      3'h6:    strap_boost = `BOOST_P6;
      default: strap_boost = `BOOST_P7;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      boost_reg   <= `BOOST_P6;
      present_reg <= 1'b0;
      active_reg  <= 1'b0;
    end else if (ce) begin
      boost_reg <= pin_mode ? strap_boost : bus_boost;
      // Separate on and off levels keep the flag from chattering near one level.
      if (!present_reg && level > on_lvl)
        present_reg <= 1'b1;
      else if (present_reg && level < off_lvl)
        present_reg <= 1'b0;
      active_reg <= power_on;
    end
  end

endmodule // lane_ctrl

`default_nettype wire

// ---- quad_repeater_smbus_config.v ----
// Configuration logic of a four-lane repeater with a chip-selected SMBus target.
// Assumes pins and detector levels arrive asynchronously and the bus wire is
// resolved outside from SDA_O and SDA_OE.
`timescale 1ns/1ps
`default_nettype none
`include "quad_repeater_defs.vh"

module quad_repeater_smbus_config #(
  parameter       LANES         = 4,
  parameter       LVL_W         = 8,
  parameter [3:0] ID_CODE       = 4'h5,  // Arbitrary value.
  parameter [15:0] IDLE_HIGH_CYC = `T_HIGH_MAX_CYC
) (
  input  wire                   CLK_SYS,
  input  wire                   RST_B,
  input  wire                   CE,
  input  wire                   PIN_MODE,
  input  wire [2:0]             BOOST_STRAP_PINS,
  input  wire [1:0]             SWING_STRAP_PIN,
  input  wire [1:0]             EMPHASIS_STRAP_PIN,
  input  wire [LANES-1:0]       LANE_POWER_ON,
  input  wire [LANES*LVL_W-1:0] LANE_LEVEL,
  input  wire                   CS,
  input  wire                   BUS_CLOCK_LINE,
  input  wire                   SDA_I,
  output reg                    SDA_O,
  output reg                    SDA_OE,
  output wire [LANES*9-1:0]     BOOST_LEVEL,
  output wire [LANES-1:0]       LANE_SIGNAL_PRESENT,
  output wire [LANES-1:0]       LANE_ACTIVE,
  output reg  [1:0]             SWING_SEL,
  output reg  [1:0]             EMPHASIS_SEL,
  output reg                    BUS_IDLE
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam SW = 11 + LANES + LANES * LVL_W;
  // Bus lines reset to their idle high level so that no false edge follows reset.
  localparam [SW-1:0] SYNC_RST = {4'h7, {(SW-4){1'b0}}};

  wire [SW-1:0] async_in = {CS, BUS_CLOCK_LINE, SDA_I, PIN_MODE, BOOST_STRAP_PINS,
                            SWING_STRAP_PIN, EMPHASIS_STRAP_PIN, LANE_POWER_ON, LANE_LEVEL};
  reg  [SW-1:0] sync1_reg;
  reg  [SW-1:0] sync2_reg;

  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      // Strap-select resets high so an open pin means strap control.
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else if (CE) begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire                   cs_s    = sync2_reg[SW-1];
  wire                   scl_s   = sync2_reg[SW-2];
  wire                   sda_s   = sync2_reg[SW-3];
  wire                   mode_s  = sync2_reg[SW-4];
  wire [2:0]             bst_s   = sync2_reg[SW-5:SW-7];
  wire [1:0]             swing_s = sync2_reg[SW-8:SW-9];
  wire [1:0]             emph_s  = sync2_reg[SW-10:SW-11];
  wire [LANES-1:0]       pwr_s   = sync2_reg[LANES*LVL_W+LANES-1:LANES*LVL_W];
  wire [LANES*LVL_W-1:0] lvl_s   = sync2_reg[LANES*LVL_W-1:0];

  // ----------------------------------------------------------------
  // Bus line events
  // ----------------------------------------------------------------
  reg scl_d_reg;
  reg sda_d_reg;

  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (CE) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  // Start and stop are only seen with the clock line high on both samples.
  wire start_ev = cs_s & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // Idle detection
  // ----------------------------------------------------------------
  localparam [15:0] TBUF_CYC = `T_BUF_CYC;

  reg [15:0] hi_cnt_reg;
  reg        after_stop_reg;
  wire       both_high  = scl_s & sda_s;
  wire       high_limit = (hi_cnt_reg >= IDLE_HIGH_CYC);

  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      hi_cnt_reg     <= 16'h0000;
      after_stop_reg <= 1'b0;
      BUS_IDLE       <= 1'b1;
    end else if (CE) begin
      if (!both_high)
        hi_cnt_reg <= 16'h0000;
      else if (!high_limit)
        hi_cnt_reg <= hi_cnt_reg + 16'h0001;
      if (start_ev) begin
        after_stop_reg <= 1'b0;
        BUS_IDLE       <= 1'b0;
      end else begin
        if (stop_ev)
          after_stop_reg <= 1'b1;
        if ((after_stop_reg && hi_cnt_reg >= TBUF_CYC) || high_limit)
          BUS_IDLE <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Target state machine
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX   = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_TX   = 3'h3;
  localparam [2:0] ST_RACK = 3'h4;

  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_PTR  = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg       read_reg;
  reg       mack_reg;
  reg [7:0] rd_data;
  // A data byte is written at the falling clock edge that ends its eighth bit.
  wire      wr_en = CE && cs_s && !stop_ev && !high_limit && !start_ev && state_reg == ST_RX &&
                    phase_reg == PH_DATA && scl_fall && bit_cnt_reg == 4'h8;

  // Register file.
  reg [7:0]       ctrl_reg;
  reg [7:0]       boost_lo_reg [0:LANES-1];
  reg [LANES-1:0] boost_hi_reg;
  reg [7:0]       det_on_reg;
  reg [7:0]       det_off_reg;

  wire [LANES-1:0] present_w;
  wire [LANES-1:0] active_w;
  wire [7:0]       rx_byte = shift_reg;

  always @* begin
    rd_data = 8'h00;
    case (ptr_reg)
      `REG_STATUS:    rd_data = {ID_CODE, present_w};
      `REG_CTRL:      rd_data = ctrl_reg;
      `REG_BOOST_MSB: rd_data = {4'h0, boost_hi_reg};
      `REG_DET_ON:    rd_data = det_on_reg;
      `REG_DET_OFF:   rd_data = det_off_reg;
      `REG_LANE_STAT: rd_data = {3'h0, mode_s, active_w};
      default: begin
        if (ptr_reg >= `REG_BOOST0 && ptr_reg <= `REG_BOOST3)
          rd_data = boost_lo_reg[ptr_reg[1:0] - 2'h2];
      end
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      // Ready at the first edge after reset, well inside the power-on limit.
      state_reg   <= ST_IDLE;
      phase_reg   <= PH_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      read_reg    <= 1'b0;
      mack_reg    <= 1'b0;
      SDA_O       <= 1'b0;
      SDA_OE      <= 1'b0;
    end else if (CE) begin
      SDA_O <= 1'b0;
      if (!cs_s || stop_ev || high_limit) begin
        // Deselect releases the line at once so other targets own the bus.
        state_reg <= ST_IDLE;
        SDA_OE    <= 1'b0;
      end else if (start_ev) begin
        state_reg   <= ST_RX;
        phase_reg   <= PH_ADDR;
        bit_cnt_reg <= 4'h0;
        SDA_OE      <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            SDA_OE <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise && bit_cnt_reg != 4'h8) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              // Drive only after the clock falls so the line is quiet while high.
              bit_cnt_reg <= 4'h0;
              case (phase_reg)
                PH_ADDR: begin
                  if (rx_byte[7:1] == `TGT_ADDR) begin
                    read_reg  <= rx_byte[0];
                    phase_reg <= PH_PTR;
                    SDA_OE    <= 1'b1;
                    state_reg <= ST_ACK;
                  end else begin
                    state_reg <= ST_IDLE;
                  end
                end
                PH_PTR: begin
                  ptr_reg   <= rx_byte;
                  phase_reg <= PH_DATA;
                  SDA_OE    <= 1'b1;
                  state_reg <= ST_ACK;
                end
                default: begin
                  SDA_OE    <= 1'b1;
                  state_reg <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (read_reg) begin
                shift_reg   <= {rd_data[6:0], 1'b0};
                SDA_OE      <= ~rd_data[7];
                bit_cnt_reg <= 4'h1;
                state_reg   <= ST_TX;
              end else begin
                SDA_OE    <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                SDA_OE    <= 1'b0;
                state_reg <= ST_RACK;
              end else begin
                SDA_OE      <= ~shift_reg[7];
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_s;
              ptr_reg  <= ptr_reg + 8'h01;
            end else if (scl_fall) begin
              if (mack_reg) begin
                shift_reg   <= {rd_data[6:0], 1'b0};
                SDA_OE      <= ~rd_data[7];
                bit_cnt_reg <= 4'h1;
                state_reg   <= ST_TX;
              end else begin
                // A NACK ends the read; the host follows with stop.
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            SDA_OE    <= 1'b0;
          end
        endcase
      end
      if (wr_en)
        ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  integer i;

  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ctrl_reg     <= `CTRL_RST;
      boost_hi_reg <= {LANES{1'b0}};
      det_on_reg   <= `DET_ON_RST;
      det_off_reg  <= `DET_OFF_RST;
      for (i = 0; i < LANES; i = i + 1)
        boost_lo_reg[i] <= `BOOST_LO_RST;
    end else if (CE && wr_en) begin
      case (ptr_reg)
        `REG_CTRL:      ctrl_reg     <= rx_byte;
        `REG_BOOST_MSB: boost_hi_reg <= rx_byte[LANES-1:0];
        `REG_DET_ON:    det_on_reg   <= rx_byte;
        `REG_DET_OFF:   det_off_reg  <= rx_byte;
        default: begin
          if (ptr_reg >= `REG_BOOST0 && ptr_reg <= `REG_BOOST3)
            boost_lo_reg[ptr_reg[1:0] - 2'h2] <= rx_byte;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Driver settings
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      SWING_SEL    <= `SWING_DEFAULT;
      EMPHASIS_SEL <= `EMPH_DEFAULT;
    end else if (CE) begin
      SWING_SEL <= ctrl_reg[`CTRL_SWING_BUS] ?
                   ctrl_reg[`CTRL_SWING_LSB+1:`CTRL_SWING_LSB] : swing_s;
      EMPHASIS_SEL <= ctrl_reg[`CTRL_EMPH_BUS] ?
                      ctrl_reg[`CTRL_EMPH_LSB+1:`CTRL_EMPH_LSB] : emph_s;
    end
  end

  // ----------------------------------------------------------------
  // Lanes
  // ----------------------------------------------------------------
  // Lane standby never gates the target above, so the bus stays reachable.
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      lane_ctrl #(
        .LVL_W (LVL_W)
      ) u_lane (
        .clk         (CLK_SYS),
        .rst_b       (RST_B),
        .ce          (CE),
        .pin_mode    (mode_s),
        .strap_code  (bst_s),
        .bus_boost   ({boost_hi_reg[g], boost_lo_reg[g]}),
        .level       (lvl_s[g*LVL_W +: LVL_W]),
        .on_lvl      (det_on_reg[LVL_W-1:0]),
        .off_lvl     (det_off_reg[LVL_W-1:0]),
        .power_on    (pwr_s[g]),
        .boost_reg   (BOOST_LEVEL[g*9 +: 9]),
        .present_reg (present_w[g]),
        .active_reg  (active_w[g])
      );
    end
  endgenerate

  assign LANE_SIGNAL_PRESENT = present_w;
  assign LANE_ACTIVE         = active_w;

endmodule // quad_repeater_smbus_config

`default_nettype wire

// ---- quad_repeater_checker_asserts.sv ----
// Port-level assertions for the repeater configuration block.
// Bound to the top module; one clock domain, CLK_SYS with RST_B low as reset.
`timescale 1ns/1ps
`default_nettype none
module quad_repeater_checker #(
  parameter        LANES         = 4,
  parameter [15:0] IDLE_HIGH_CYC = 16'h1388
) (
  input wire logic               CLK_SYS,
  input wire logic               RST_B,
  input wire logic               CE,
  input wire logic               PIN_MODE,
  input wire logic [2:0]         BOOST_STRAP_PINS,
  input wire logic [LANES-1:0]   LANE_POWER_ON,
  input wire logic               CS,
  input wire logic               BUS_CLOCK_LINE,
  input wire logic               SDA_I,
  input wire logic               SDA_O,
  input wire logic               SDA_OE,
  input wire logic [LANES*9-1:0] BOOST_LEVEL,
  input wire logic [LANES-1:0]   LANE_SIGNAL_PRESENT,
  input wire logic [LANES-1:0]   LANE_ACTIVE,
  input wire logic               BUS_IDLE
);
  localparam logic [8:0] PAT [8] = '{9'h000, 9'h001, 9'h003, 9'h007, 9'h00F, 9'h01F, 9'h02F, 9'h03F};
  logic [2:0]  pm_cnt;
  logic [15:0] hi_cnt;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Strap values need a few cycles to cross the synchronisers, so only
  // a strap that has been steady for a while is compared.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B || !CE || !PIN_MODE || !$stable(BOOST_STRAP_PINS)) pm_cnt <= 3'h0;
    else if (pm_cnt != 3'h7) pm_cnt <= pm_cnt + 3'h1;
    if (!RST_B || !BUS_CLOCK_LINE || !SDA_I) hi_cnt <= 16'h0000;
    else if (hi_cnt != 16'hFFFF) hi_cnt <= hi_cnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  strap_boost_all_a: assert property (pm_cnt == 3'h6 |-> BOOST_LEVEL == {LANES{PAT[BOOST_STRAP_PINS]}})
    else $error("boost differs from strap pattern");
  lanes_follow_enable_a: assert property ($stable(LANE_POWER_ON) [*5] |-> LANE_ACTIVE == LANE_POWER_ON)
    else $error("lane standby does not follow enable");
  deselect_silent_a: assert property (!CS [*4] |-> !SDA_OE)
    else $error("data line driven while deselected");
  oe_scl_low_a: assert property ($changed(SDA_OE) |-> !BUS_CLOCK_LINE || !CS)
    else $error("data drive changed while clock high");
  ack_drives_low_a: assert property (SDA_OE |-> SDA_O == 1'b0)
    else $error("driven data level is not low");
  idle_not_early_a: assert property ($rose(BUS_IDLE) |-> hi_cnt >= 16'h01D6)
    else $error("idle declared before bus free time");
  idle_reached_a: assert property (hi_cnt == IDLE_HIGH_CYC + 16'h0010 |-> BUS_IDLE)
    else $error("idle missing after long high time");
  busy_in_frame_a: assert property ((CS && !BUS_CLOCK_LINE) [*4] |-> !BUS_IDLE)
    else $error("idle reported inside a frame");

  cover property ($rose(SDA_OE));
  cover property ($fell(BUS_IDLE));
  cover property ($rose(LANE_SIGNAL_PRESENT[0]));
endmodule // quad_repeater_checker

bind quad_repeater_smbus_config quad_repeater_checker #(.LANES(LANES), .IDLE_HIGH_CYC(IDLE_HIGH_CYC)) chk (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .PIN_MODE(PIN_MODE), .BOOST_STRAP_PINS(BOOST_STRAP_PINS),
  .LANE_POWER_ON(LANE_POWER_ON), .CS(CS), .BUS_CLOCK_LINE(BUS_CLOCK_LINE), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE), .BOOST_LEVEL(BOOST_LEVEL), .LANE_SIGNAL_PRESENT(LANE_SIGNAL_PRESENT),
  .LANE_ACTIVE(LANE_ACTIVE), .BUS_IDLE(BUS_IDLE));
`default_nettype wire

// ---- smbus_host_model.sv ----
// Host bus master model with its own chip-select line.
// Assumes the bench resolves the data wire with a pull-up and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  output var logic scl,
  output var logic pull,
  output var logic cs,
  input  wire logic sda
);
  // The clock stands high between frames; tasks other than a frame's first start begin at a falling clock edge.
  initial begin
    scl = 1'b1;
    pull = 1'b0;
    cs = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus primitives
  // ----------------------------------------------------------------
  // Also serves as a repeated start, since the line is released first.
  task automatic start(input logic sel);
    cs = sel;
    pull = 1'b0;
    #80 scl = 1'b1;
    #80 pull = 1'b1;
    #80 scl = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      pull = ~d[i];
      #80 scl = 1'b1;
      #40 q[i] = sda;
      #40 scl = 1'b0;
    end
    pull = ~ack_in;
    #80 scl = 1'b1;
    #40 ack = sda;
    #40 scl = 1'b0;
  endtask

  task automatic stop();
    pull = 1'b1;
    #80 scl = 1'b1;
    #80 pull = 1'b0;
    #80 cs = 1'b0;
    #4800;
  endtask
endmodule // smbus_host_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the repeater configuration block.
// Straps, enables and levels are driven directly; bus traffic uses the host model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [8:0] PAT [8] = '{9'h000, 9'h001, 9'h003, 9'h007, 9'h00F, 9'h01F, 9'h02F, 9'h03F};
  logic        clk;
  logic        rst_b;
  logic        ce;
  logic        pin_mode;
  logic [2:0]  boost_strap;
  logic [1:0]  swing_strap;
  logic [1:0]  emph_strap;
  logic [3:0]  power_on;
  logic [31:0] level;
  logic        scl;
  logic        pull;
  logic        cs;
  logic        sda_o;
  logic        sda_oe;
  wire logic   sda;
  logic [35:0] boost;
  logic [3:0]  present;
  logic [3:0]  active;
  logic [1:0]  swing;
  logic [1:0]  emph;
  logic        bus_idle;
  logic [7:0]  q;
  logic        a;
  logic [15:0] r;
  int          n_errors = 0;
  int          checks = 0;

  assign sda = ~pull & (~sda_oe | sda_o);

  // ID_CODE value is arbitrary.
  quad_repeater_smbus_config #(.ID_CODE(4'hA), .IDLE_HIGH_CYC(16'h0258)) dut (
    .CLK_SYS(clk), .RST_B(rst_b), .CE(ce), .PIN_MODE(pin_mode), .BOOST_STRAP_PINS(boost_strap),
    .SWING_STRAP_PIN(swing_strap), .EMPHASIS_STRAP_PIN(emph_strap), .LANE_POWER_ON(power_on),
    .LANE_LEVEL(level), .CS(cs), .BUS_CLOCK_LINE(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .BOOST_LEVEL(boost), .LANE_SIGNAL_PRESENT(present), .LANE_ACTIVE(active), .SWING_SEL(swing),
    .EMPHASIS_SEL(emph), .BUS_IDLE(bus_idle));
  smbus_host_model host (.scl(scl), .pull(pull), .cs(cs), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Burst write; bytes go out from d[7:0] upward. Acks are expected only
  // when selected and addressed correctly.
  task automatic wr(input logic sel, input logic [7:0] adr, input logic [7:0] ptr, input logic [39:0] d,
                    input int n);
    logic ok;
    ok = sel && adr == 8'hAC;
    host.start(sel);
    host.xfer(adr, 1'b1, q, a);
    chk(a, !ok);
    host.xfer(ptr, 1'b1, q, a);
    chk(a, !ok);
    for (int i = 0; i < n; i++) begin
      host.xfer(d[8*i +: 8], 1'b1, q, a);
      chk(a, !ok);
    end
    host.stop();
  endtask

  task automatic rd(input logic [7:0] ptr, input int n);
    host.start(1'b1);
    host.xfer(8'hAC, 1'b1, q, a);
    host.xfer(ptr, 1'b1, q, a);
    host.start(1'b1);
    host.xfer(8'hAD, 1'b1, q, a);
    chk(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hFF, i == n - 1, q, a);
      r = {r[7:0], q};
    end
    host.stop();
  endtask

  task automatic lvl(input logic [7:0] v, input logic e);
    level[7:0] = v;
    repeat (8) @(negedge clk);
    chk(present[0], e);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    pin_mode = 1'b1;
    boost_strap = 3'h6;
    swing_strap = 2'h2;
    emph_strap = 2'h2;
    power_on = 4'hF;
    level = 32'h0;
    r = 16'h0000;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    chk(boost, {4{PAT[6]}});
    chk({swing, emph}, 4'hA);
    for (int c = 0; c < 8; c++) begin
      boost_strap = c[2:0];
      swing_strap = c[1:0];
      emph_strap = ~c[1:0];
      repeat (8) @(negedge clk);
      chk(boost, {4{PAT[c]}});
      chk({swing, emph}, {c[1:0], ~c[1:0]});
    end
    // Clock enable low must hold the lanes at their last boost.
    ce = 1'b0;
    boost_strap = 3'h1;
    repeat (8) @(negedge clk);
    chk(boost, {4{PAT[7]}});
    ce = 1'b1;
    repeat (8) @(negedge clk);
    chk(boost, {4{PAT[1]}});
    wr(1'b0, 8'hAC, 8'h01, 40'h1F, 1);
    wr(1'b1, 8'hAE, 8'h01, 40'h1F, 1);
    pin_mode = 1'b0;
    power_on = 4'h0;
    // Lanes sit in standby while the bus is used.
    wr(1'b1, 8'hAC, 8'h02, 40'h0F44332211, 5);
    repeat (8) @(negedge clk);
    chk(boost, {9'h144, 9'h133, 9'h122, 9'h111});
    chk(active, 4'h0);
    rd(8'h03, 2);
    chk(r, 16'h2233);
    rd(8'h01, 1);
    chk(r[7:0], 8'h28);
    power_on = 4'h5;
    wr(1'b1, 8'hAC, 8'h01, 40'h1F, 1);
    repeat (8) @(negedge clk);
    chk({swing, emph, active}, {2'h3, 2'h1, 4'h5});
    rd(8'h09, 1);
    chk(r[7:0], 8'h05);
    lvl(8'h41, 1'b1);
    lvl(8'h20, 1'b1);
    rd(8'h00, 1);
    chk(r[7:0], 8'hA1);
    lvl(8'h1F, 1'b0);
    wr(1'b1, 8'hAC, 8'h07, 40'h6080, 2);
    lvl(8'h70, 1'b0);
    lvl(8'h81, 1'b1);
    lvl(8'h61, 1'b1);
    lvl(8'h5F, 1'b0);
    rd(8'h08, 1);
    chk(r[7:0], 8'h60);
    chk(bus_idle, 1'b1);
    close_out();
  end

  initial begin
    #500000;
    n_errors++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
